// ==== rdtp_pkg.sv ====
// constants and types for the reload down timer pair
package rdtp_pkg;
    localparam int ADDR_W = 6;
    localparam logic [5:0] ADDR_T2_CTRL   = 6'h19;
    localparam logic [5:0] ADDR_T2_RLD_HI = 6'h1A;
    localparam logic [5:0] ADDR_T2_RLD_LO = 6'h1B;
    localparam logic [5:0] ADDR_T2_CNT_HI = 6'h1C;
    localparam logic [5:0] ADDR_T2_CNT_LO = 6'h1D;
    localparam logic [5:0] ADDR_T3_CTRL   = 6'h1E;
    localparam logic [5:0] ADDR_T3_RLD_HI = 6'h1F;
    localparam logic [5:0] ADDR_T3_RLD_LO = 6'h20;
    localparam logic [5:0] ADDR_T3_CNT_HI = 6'h21;
    localparam logic [5:0] ADDR_T3_CNT_LO = 6'h22;
    localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h30;
    localparam logic [7:0] CTRL_RW_MASK   = 8'hBB;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] RLD_RESET      = 8'h00;
    localparam logic [15:0] CNT_ZERO      = 16'h0000;
    localparam logic [15:0] CNT_ONE       = 16'h0001;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    // start mode codes
    typedef enum logic [1:0] {
        START_NONE    = 2'h0,
        START_TX_END  = 2'h1,
        START_TRIM    = 2'h2,
        START_TRIM_UF = 2'h3
    } rdtp_start_type;
    // clock source codes
    typedef enum logic [1:0] {
        CLK_FAST  = 2'h0,
        CLK_SLOW  = 2'h1,
        CLK_UF_T0 = 2'h2,
        CLK_UF_T1 = 2'h3
    } rdtp_clksel_type;
    // control register layout, msb first
    typedef struct packed {
        logic            stop_on_receive;
        logic            rsvd6;
        rdtp_start_type  start_mode;
        logic            auto_reload;
        logic            rsvd2;
        rdtp_clksel_type clock_select;
    } rdtp_ctrl_type;
    // register port request
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rdtp_req_type;
    // frontend events, all on clk_sys
    typedef struct packed {
        logic tick_fast;
        logic tick_slow;
        logic uf_first;
        logic uf_second;
        logic tx_end;
        logic rx_nibble;
    } rdtp_evt_type;
endpackage

// ==== rdtp_timer_pair.sv ====
// two reload down timers with control, reload and live count registers
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns
module rdtp_timer_pair (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire rdtp_pkg::rdtp_req_type req,
    input  wire rdtp_pkg::rdtp_evt_type evt,
    input  wire logic                  trim_in,
    output logic [7:0]                 rdata,
    output logic                       t2_running,
    output logic                       t3_running,
    output logic                       second_underflow_irq_flag,
    output logic                       underflow_irq_flag
);
    import rdtp_pkg::*;

    logic          rst_s1_ff;
    logic          rst_s2_ff;
    logic          trim_s1_ff;
    logic          trim_s2_ff;
    logic          trim_s3_ff;
    logic          trim_lvl_ff;
    logic          trim_rise;
    rdtp_ctrl_type ctrl_ff [2];
    logic [7:0]    rld_hi_ff [2];
    logic [7:0]    rld_lo_ff [2];
    logic [15:0]   cnt_ff [2];
    logic          run_ff [2];
    logic          uf [2];
    logic          tick [2];
    logic          start_ev [2];
    logic          stop_ev [2];
    logic          irq_ff [2];
    logic [7:0]    rdata_ff;
    logic [7:0]    nxt_rdata;

    // merge of reload bytes into one word
    function automatic logic [15:0] reload_word(input logic [7:0] hi, input logic [7:0] lo);
        return {hi, lo};
    endfunction

    // source select for one timer
    function automatic logic pick_tick(input rdtp_clksel_type sel, input rdtp_evt_type e);
        case (sel)
            CLK_FAST:  pick_tick = e.tick_fast;
            CLK_SLOW:  pick_tick = e.tick_slow;
            CLK_UF_T0: pick_tick = e.uf_first;
            CLK_UF_T1: pick_tick = e.uf_second;
            default:   pick_tick = 1'b0;
        endcase
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end

    // trim pin synchroniser, change counts when stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            trim_s1_ff  <= 1'b0;
            trim_s2_ff  <= 1'b0;
            trim_s3_ff  <= 1'b0;
            trim_lvl_ff <= 1'b0;
        end else if (clk_en) begin
            trim_s1_ff <= trim_in;
            trim_s2_ff <= trim_s1_ff;
            trim_s3_ff <= trim_s2_ff;
            if (trim_s2_ff == trim_s3_ff) begin
                trim_lvl_ff <= trim_s3_ff;
            end
        end
    end

    assign trim_rise = (trim_s2_ff == trim_s3_ff) && trim_s3_ff && !trim_lvl_ff;

    // per timer start, stop and tick decode
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            tick[i] = pick_tick(ctrl_ff[i].clock_select, evt);
            case (ctrl_ff[i].start_mode)
                START_TX_END:  start_ev[i] = evt.tx_end;
                START_TRIM:    start_ev[i] = trim_rise && !run_ff[i];
                START_TRIM_UF: start_ev[i] = trim_rise && !run_ff[i];
                default:       start_ev[i] = 1'b0;
            endcase
            // stop on nibble, not in trim modes
            if (ctrl_ff[i].start_mode[1]) begin
                stop_ev[i] = trim_rise && run_ff[i];
            end else begin
                stop_ev[i] = ctrl_ff[i].stop_on_receive && evt.rx_nibble;
            end
            uf[i] = run_ff[i] && tick[i] && (cnt_ff[i] == CNT_ZERO);
        end
    end

    // control and reload registers
    always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_ff[i]   <= rdtp_ctrl_type'(CTRL_RESET);
                rld_hi_ff[i] <= RLD_RESET;
                rld_lo_ff[i] <= RLD_RESET;
            end
        end else if (clk_en && req.wr) begin
            case (req.addr)
                ADDR_T2_CTRL:   ctrl_ff[0] <= rdtp_ctrl_type'(req.wdata & CTRL_RW_MASK);
                ADDR_T3_CTRL:   ctrl_ff[1] <= rdtp_ctrl_type'(req.wdata & CTRL_RW_MASK);
                ADDR_T2_RLD_HI: rld_hi_ff[0] <= req.wdata;
                ADDR_T2_RLD_LO: rld_lo_ff[0] <= req.wdata;
                ADDR_T3_RLD_HI: rld_hi_ff[1] <= req.wdata;
                ADDR_T3_RLD_LO: rld_lo_ff[1] <= req.wdata;
                default: ;
            endcase
        end
    end

    // counters
    always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            for (int i = 0; i < 2; i++) begin
                cnt_ff[i] <= CNT_ZERO;
                run_ff[i] <= 1'b0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (start_ev[i]) begin
                    cnt_ff[i] <= reload_word(rld_hi_ff[i], rld_lo_ff[i]);
                    run_ff[i] <= 1'b1;
                end else if (stop_ev[i]) begin
                    run_ff[i] <= 1'b0;
                end else if (uf[i]) begin
                    if (ctrl_ff[i].auto_reload) begin
                        cnt_ff[i] <= reload_word(rld_hi_ff[i], rld_lo_ff[i]);
                    end else begin
                        run_ff[i] <= 1'b0;
                    end
                end else if (run_ff[i] && tick[i]) begin
                    cnt_ff[i] <= cnt_ff[i] - CNT_ONE;
                end
            end
        end
    end

    // underflow flags, set wins over clear-on-write
    always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            irq_ff[0] <= 1'b0;
            irq_ff[1] <= 1'b0;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (uf[i] && ctrl_ff[i].start_mode != START_TRIM) begin
                    irq_ff[i] <= 1'b1;
                end else if (req.wr && req.addr == ADDR_IRQ_FLAGS && req.wdata[i]) begin
                    irq_ff[i] <= 1'b0;
                end
            end
        end
    end

    // read mux
    always_comb begin
        nxt_rdata = BYTE_ZERO;
        case (req.addr)
            ADDR_T2_CTRL:   nxt_rdata = ctrl_ff[0];
            ADDR_T2_RLD_HI: nxt_rdata = rld_hi_ff[0];
            ADDR_T2_RLD_LO: nxt_rdata = rld_lo_ff[0];
            ADDR_T2_CNT_HI: nxt_rdata = cnt_ff[0][15:8];
            ADDR_T2_CNT_LO: nxt_rdata = cnt_ff[0][7:0];
            ADDR_T3_CTRL:   nxt_rdata = ctrl_ff[1];
            ADDR_T3_RLD_HI: nxt_rdata = rld_hi_ff[1];
            ADDR_T3_RLD_LO: nxt_rdata = rld_lo_ff[1];
            ADDR_T3_CNT_HI: nxt_rdata = cnt_ff[1][15:8];
            ADDR_T3_CNT_LO: nxt_rdata = cnt_ff[1][7:0];
            ADDR_IRQ_FLAGS: nxt_rdata = {6'h00, irq_ff[1], irq_ff[0]};
            default:        nxt_rdata = BYTE_ZERO;
        endcase
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge clk_sys or negedge rst_s2_ff) begin
        if (!rst_s2_ff) begin
            rdata_ff <= BYTE_ZERO;
        end else if (clk_en) begin
            rdata_ff <= req.rd ? nxt_rdata : BYTE_ZERO;
        end
    end

    assign rdata                     = rdata_ff;
    assign t2_running                = run_ff[0];
    assign t3_running                = run_ff[1];
    assign second_underflow_irq_flag = irq_ff[0];
    assign underflow_irq_flag        = irq_ff[1];
endmodule // rdtp_timer_pair

// ==== rdtp_timer_pair_sva.sv ====
// port assertions for the reload down timer pair
`timescale 1ns/1ns
module rdtp_timer_pair_sva (
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    input wire logic                   clk_en,
    input wire rdtp_pkg::rdtp_req_type req,
    input wire rdtp_pkg::rdtp_evt_type evt,
    input wire logic                   trim_in,
    input wire logic [7:0]             rdata,
    input wire logic                   t2_running,
    input wire logic                   t3_running,
    input wire logic                   second_underflow_irq_flag,
    input wire logic                   underflow_irq_flag
);
    import rdtp_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rdata_idle_zero: assert property (clk_en && !req.rd |=> rdata == BYTE_ZERO)
        else $error("read data not zero outside a read");
    a_ctrl_rsvd_zero: assert property (clk_en && req.rd &&
        (req.addr == ADDR_T3_CTRL || req.addr == ADDR_T2_CTRL) |=> (rdata & 8'h44) == BYTE_ZERO)
        else $error("reserved control bits read back set");
    a_unmapped_zero: assert property (clk_en && req.rd && req.addr == 6'h3F |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_t3_flag_hold: assert property (underflow_irq_flag && clk_en &&
        !(req.wr && req.addr == ADDR_IRQ_FLAGS && req.wdata[1]) |=> underflow_irq_flag)
        else $error("timer three flag dropped without clear");
    a_t2_flag_hold: assert property (second_underflow_irq_flag && clk_en &&
        !(req.wr && req.addr == ADDR_IRQ_FLAGS && req.wdata[0]) |=> second_underflow_irq_flag)
        else $error("timer two flag dropped without clear");
    a_t3_flag_cause: assert property ($rose(underflow_irq_flag) |-> $past(t3_running))
        else $error("timer three flag set while idle");
    a_t3_start_cause: assert property ($rose(t3_running) |-> $past(evt.tx_end) ||
        $past(trim_in, 3) || $past(trim_in, 4) || $past(trim_in, 5))
        else $error("timer three started without start event");
    a_t2_start_cause: assert property ($rose(t2_running) |-> $past(evt.tx_end) ||
        $past(trim_in, 3) || $past(trim_in, 4) || $past(trim_in, 5))
        else $error("timer two started without start event");
endmodule // rdtp_timer_pair_sva
bind rdtp_timer_pair rdtp_timer_pair_sva rdtp_timer_pair_sva_inst (.clk_sys(clk_sys),
    .rst_n(rst_n), .clk_en(clk_en), .req(req), .evt(evt), .trim_in(trim_in), .rdata(rdata),
    .t2_running(t2_running), .t3_running(t3_running),
    .second_underflow_irq_flag(second_underflow_irq_flag),
    .underflow_irq_flag(underflow_irq_flag));

// ==== tb_top.sv ====
// self-checking bench for the reload down timer pair
`timescale 1ns/1ns
module tb_top;
    import rdtp_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_n   = 1'b0;
    rdtp_req_type req     = '0;
    rdtp_evt_type evt     = '0;
    logic [7:0]   rdata;
    logic         t2_run, t3_run, uf2, uf3;
    logic         clk_en  = 1'b1;
    logic         trim_in = 1'b0;
    int           n_fail = 0, total_checks = 0, cyc = 0;
    logic [5:0]   rld[4] = '{ADDR_T2_RLD_HI, ADDR_T2_RLD_LO, ADDR_T3_RLD_HI, ADDR_T3_RLD_LO};
    rdtp_timer_pair rdtp_timer_pair_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .req(req), .evt(evt), .trim_in(trim_in), .rdata(rdata), .t2_running(t2_run),
        .t3_running(t3_run), .second_underflow_irq_flag(uf2), .underflow_irq_flag(uf3));
    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;
    task automatic close_out();
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one status pin against its expected level
    task automatic chk_pin(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // trim pin held high long enough to pass the synchroniser, then low again
    task automatic trim_edge();
        @(posedge clk_sys);
        trim_in <= 1'b1;
        repeat (5) @(posedge clk_sys);
        trim_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // one-cycle write strobe
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    // one-cycle read strobe, answer looked at in the following cycle
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // one-cycle pulse on one event line
    task automatic pulse(input int b);
        @(posedge clk_sys);
        evt[b] <= 1'b1;
        @(posedge clk_sys);
        evt[b] <= 1'b0;
    endtask
    // hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        // reload bytes, control mask, unmapped place
        for (int i = 0; i < 4; i++) begin
            wr(rld[i], 8'h5A ^ 8'(i));
            rd(rld[i], 8'h5A ^ 8'(i));
        end
        wr(ADDR_T3_CTRL, 8'hFF);
        rd(ADDR_T3_CTRL, CTRL_RW_MASK);
        rd(6'h3F, 8'h00);
        // each clock source code advances only on its own tick; late reload write ignored
        for (int t = 0; t < 2; t++) begin
            for (int cs = 0; cs < 4; cs++) begin
                wr(t ? ADDR_T3_RLD_HI : ADDR_T2_RLD_HI, 8'h01);
                wr(t ? ADDR_T3_RLD_LO : ADDR_T2_RLD_LO, 8'h03);
                wr(t ? ADDR_T3_CTRL : ADDR_T2_CTRL, 8'h10 | 8'(cs));
                pulse(1);
                wr(t ? ADDR_T3_RLD_LO : ADDR_T2_RLD_LO, 8'hAB);
                for (int b = 5; b > 1; b--) pulse(b);
                rd(t ? ADDR_T3_CNT_HI : ADDR_T2_CNT_HI, 8'h01);
                rd(t ? ADDR_T3_CNT_LO : ADDR_T2_CNT_LO, 8'h02);
            end
        end
        // count through zero, then stop or reload
        for (int ar = 0; ar < 2; ar++) begin
            wr(ADDR_T3_RLD_HI, 8'h00);
            wr(ADDR_T3_RLD_LO, 8'h01);
            wr(ADDR_T3_CTRL, ar ? 8'h18 : 8'h10);
            wr(ADDR_IRQ_FLAGS, 8'h03);
            pulse(1);
            pulse(5);
            pulse(5);
            rd(ADDR_IRQ_FLAGS, 8'h02);
            chk({7'h00, t3_run}, 8'(ar));
            rd(ADDR_T3_CNT_LO, 8'(ar));
        end
        wr(ADDR_IRQ_FLAGS, 8'h02);
        rd(ADDR_IRQ_FLAGS, 8'h00);
        // first received nibble halts only with the stop bit set
        for (int s = 0; s < 2; s++) begin
            wr(ADDR_T3_CTRL, s ? 8'h90 : 8'h10);
            pulse(1);
            pulse(0);
            @(posedge clk_sys);
            #1 chk({7'h00, t3_run}, 8'(1 - s));
        end
        // trim modes: pin edges start and stop, nibble ignored, underflow flag only in START_TRIM_UF
        wr(ADDR_T3_RLD_LO, 8'h02);
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_IRQ_FLAGS, 8'h03);
            wr(ADDR_T3_CTRL, m ? 8'hB0 : 8'hA0);
            trim_edge();
            pulse(0);
            #1 chk_pin(t3_run, 1'b1);
            pulse(5);
            trim_edge();
            pulse(5);
            #1 chk_pin(t3_run, 1'b0);
            rd(ADDR_T3_CNT_LO, 8'h01);
            trim_edge();
            repeat (3) pulse(5);
            #1 chk_pin(t3_run, 1'b0);
            #1 chk_pin(uf3, 1'(m));
        end
        // timer two counts through zero and raises its own flag
        wr(ADDR_T2_RLD_HI, 8'h00);
        wr(ADDR_T2_RLD_LO, 8'h01);
        wr(ADDR_T2_CTRL, 8'h10);
        wr(ADDR_IRQ_FLAGS, 8'h03);
        pulse(1);
        #1 chk_pin(t2_run, 1'b1);
        pulse(5);
        pulse(5);
        #1 chk_pin(t2_run, 1'b0);
        #1 chk_pin(uf2, 1'b1);
        #1 chk_pin(uf3, 1'b0);
        // clock enable low freezes the count
        wr(ADDR_T3_CTRL, 8'h10);
        pulse(1);
        clk_en <= 1'b0;
        pulse(5);
        clk_en <= 1'b1;
        rd(ADDR_T3_CNT_LO, 8'h02);
        close_out();
    end
endmodule // tb_top
